// ==== rtl/atqe_engine.sv ====
// address table query engine: apb register file, search state machine and
// the address table held in flip-flops.
// assumes an apb master on core_clk_i and a learning block that fills
// entries through the entry write port.
`timescale 1ns/1ns

module atqe_engine #(
  parameter int unsigned DEPTH = atqe_pkg::TABLE_DEPTH  // table entries
) (
  input  wire logic                   core_clk_i,  // 125 MHz clock
  input  wire logic                   rst_n_i,     // synchronous reset, low
  input  wire atqe_pkg::atqe_apb_req_t apb_req_i,  // apb request
  output logic [31:0]                 prdata_o,    // apb read data
  output logic                        pready_o,    // apb ready
  output logic                        pslverr_o,   // apb error, unmapped
  input  wire logic                   ent_we_i,    // entry write strobe
  input  wire logic [$clog2(DEPTH)-1:0] ent_idx_i, // entry write index
  input  wire atqe_pkg::atqe_entry_t  ent_i,       // entry write data
  output logic                        busy_o,      // command executing
  output logic                        irq_o        // masked command done
);
  import atqe_pkg::*;

  localparam int unsigned IW = $clog2(DEPTH);          // index width
  localparam logic [IW-1:0] LAST = IW'(DEPTH - 1);     // highest index

  // the index arithmetic wraps at a power of two only, so refuse others at elaboration
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("atqe_engine: DEPTH must be a power of two, at least 2");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_CLEAR} atqe_state_t;

  atqe_state_t   state_ff;                 // engine state
  atqe_entry_t   table_ff [DEPTH];         // the address table
  logic [7:0]    param_ff [PARAM_BYTES];   // parameter bytes
  logic [7:0]    cmd_ff;                   // last command code
  logic [7:0]    result_ff;                // result code register
  logic [IW-1:0] rd_ptr_ff;                // read pointer
  logic [IW-1:0] scan_idx_ff;              // entry under test
  atqe_sel_t     sel_ff;                   // property searched for
  logic          src_done_ff;              // sticky command done source
  logic          mask_done_ff;             // command done enable
  logic          irq_ff;                   // interrupt line
  logic          busy_ff;                  // busy line
  logic [31:0]   prdata_ff;                // registered read data
  logic          pready_ff;                // high in the access cycle
  logic          pslverr_ff;               // error in the access cycle

  logic          setup_ph;     // apb setup cycle
  logic          wr_acc;       // write taking effect this edge
  logic          cmd_go;       // command accepted
  logic          dec_search;   // command is a search
  logic          dec_next;     // search starts after the pointer
  atqe_sel_t     dec_sel;      // decoded property
  atqe_entry_t   cur_ent;      // entry under test
  logic          ent_match;    // entry under test matches
  logic          hit;          // search found its entry
  logic          miss_end;     // search ran off the end
  logic          done_pulse;   // command finished this edge
  logic          next_at_end;  // next search with pointer on last entry
  logic [31:0]   nxt_prdata;   // read data for this setup cycle
  logic          nxt_pslverr;  // address not mapped

  assign setup_ph = apb_req_i.psel & ~apb_req_i.penable;
  assign wr_acc   = apb_req_i.psel & apb_req_i.penable & pready_ff & apb_req_i.pwrite;
  // commands are taken only while idle; a write while busy is dropped
  assign cmd_go   = wr_acc && (apb_req_i.paddr == OFS_CMD) && (state_ff == ST_IDLE);

  // command decode
  always_comb begin
    dec_search = 1'b1;
    dec_next   = 1'b0;
    dec_sel    = SEL_VALID;
    case (apb_req_i.pwdata[7:0])
      CMD_NEXT_VALID: begin dec_next = 1'b1; dec_sel = SEL_VALID; end
      CMD_FIRST_NEW:  begin dec_sel = SEL_NEW; end
      CMD_NEXT_NEW:   begin dec_next = 1'b1; dec_sel = SEL_NEW; end
      CMD_FIRST_AGED: begin dec_sel = SEL_AGED; end
      CMD_NEXT_AGED:  begin dec_next = 1'b1; dec_sel = SEL_AGED; end
      CMD_FIRST_LOCK: begin dec_sel = SEL_LOCK; end
      CMD_NEXT_LOCK:  begin dec_next = 1'b1; dec_sel = SEL_LOCK; end
      CMD_FIRST_FILT: begin dec_sel = SEL_FILT; end
      CMD_NEXT_FILT:  begin dec_next = 1'b1; dec_sel = SEL_FILT; end
      CMD_FIRST_PORT: begin dec_sel = SEL_PORT; end
      CMD_NEXT_PORT:  begin dec_next = 1'b1; dec_sel = SEL_PORT; end
      default:        begin dec_search = 1'b0; end                     // reset or unserved
    endcase
  end

  // match test on the entry under the scan index
  assign cur_ent = table_ff[scan_idx_ff];
  always_comb begin
    case (sel_ff)
      SEL_VALID: ent_match = cur_ent.flags[FLG_VALID];
      SEL_NEW:   ent_match = cur_ent.flags[FLG_NEW];
      SEL_AGED:  ent_match = cur_ent.flags[FLG_OLD];
      SEL_LOCK:  ent_match = cur_ent.flags[FLG_LOCK];
      SEL_FILT:  ent_match = cur_ent.flags[FLG_FILTER];
      // byte six was loaded by software before the command
      SEL_PORT:  ent_match = cur_ent.flags[FLG_VALID]
                           && (cur_ent.port == param_ff[6]);
      default:   ent_match = 1'b0;
    endcase
  end

  assign hit         = (state_ff == ST_SCAN) && ent_match;
  assign miss_end    = (state_ff == ST_SCAN) && !ent_match && (scan_idx_ff == LAST);
  assign next_at_end = dec_next && (rd_ptr_ff == LAST);
  assign done_pulse  = hit || miss_end || (state_ff == ST_CLEAR)
                    || (cmd_go && !dec_search && apb_req_i.pwdata[7:0] != CMD_SYS_RESET)
                    || (cmd_go && dec_search && next_at_end);

  // search state machine, scan index, read pointer and result code
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_ff    <= ST_IDLE;
      scan_idx_ff <= '0;
      rd_ptr_ff   <= '0;
      sel_ff      <= SEL_VALID;
      result_ff   <= RES_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (cmd_go) begin
            sel_ff <= dec_sel;
            if (apb_req_i.pwdata[7:0] == CMD_SYS_RESET) begin
              state_ff  <= ST_CLEAR;
              result_ff <= RES_BUSY;
            end else if (!dec_search) begin
              result_ff <= RES_BAD_CMD;                   // code not served here
            end else if (next_at_end) begin
              result_ff <= RES_NOT_FOUND;                 // nothing after the last entry
            end else begin
              state_ff    <= ST_SCAN;
              result_ff   <= RES_BUSY;
              // a next search skips the entry last returned
              scan_idx_ff <= dec_next ? rd_ptr_ff + 1'b1 : '0;
            end
          end
        end
        ST_SCAN: begin
          // one entry per clock: a full miss costs DEPTH cycles
          if (hit) begin
            state_ff  <= ST_IDLE;
            rd_ptr_ff <= scan_idx_ff;
            result_ff <= RES_OK;
          end else if (miss_end) begin
            state_ff  <= ST_IDLE;                         // pointer left alone
            result_ff <= RES_NOT_FOUND;
          end else begin
            scan_idx_ff <= scan_idx_ff + 1'b1;            // ascending order
          end
        end
        ST_CLEAR: begin
          state_ff    <= ST_IDLE;
          rd_ptr_ff   <= '0;
          scan_idx_ff <= '0;
          result_ff   <= RES_OK;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // address table: cleared by the reset command, else filled by the learner
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        table_ff[i] <= '0;
      end
    end else if (state_ff == ST_CLEAR) begin
      // clear beats a learner write in the same cycle
      for (int i = 0; i < DEPTH; i++) begin
        table_ff[i] <= '0;
      end
    end else if (ent_we_i) begin
      table_ff[ent_idx_i] <= ent_i;
    end
  end

  // parameter bytes: loaded from a hit, else written by software while idle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < PARAM_BYTES; i++) begin
        param_ff[i] <= RST_BYTE;
      end
    end else if (hit) begin
      // of the search outcomes, only a hit touches the bytes
      for (int i = 0; i < 6; i++) begin
        param_ff[i] <= cur_ent.mac[8*i +: 8];
      end
      param_ff[6] <= cur_ent.port;
      param_ff[7] <= cur_ent.flags & FLG_MASK;
    end else if (state_ff == ST_CLEAR) begin
      for (int i = 0; i < PARAM_BYTES; i++) begin
        param_ff[i] <= RST_BYTE;
      end
    end else if (wr_acc && state_ff == ST_IDLE && apb_req_i.paddr <= OFS_PARAM7
                 && apb_req_i.paddr[1:0] == 2'b00) begin
      param_ff[apb_req_i.paddr[4:2]] <= apb_req_i.pwdata[7:0];
    end
  end

  // command code register keeps the last accepted code for readback
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cmd_ff <= RST_BYTE;
    end else if (cmd_go) begin
      cmd_ff <= apb_req_i.pwdata[7:0];
    end
  end

  // command done source: write one to clear, a new done wins over the clear
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      src_done_ff <= 1'b0;
    end else if (done_pulse) begin
      src_done_ff <= 1'b1;
    end else if (wr_acc && apb_req_i.paddr == OFS_INT_SRC
                 && apb_req_i.pwdata[INT_DONE_BIT]) begin
      src_done_ff <= 1'b0;
    end
  end

  // mask register, one enable bit
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mask_done_ff <= 1'b0;
    end else if (wr_acc && apb_req_i.paddr == OFS_INT_MASK) begin
      mask_done_ff <= apb_req_i.pwdata[INT_DONE_BIT];
    end
  end

  // interrupt and busy lines, registered so they leave from a flip-flop
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_ff  <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      irq_ff  <= src_done_ff & mask_done_ff;
      busy_ff <= (state_ff != ST_IDLE);
    end
  end

  // read decode for the setup cycle
  always_comb begin
    nxt_prdata  = RST_WORD;
    nxt_pslverr = 1'b0;
    if (apb_req_i.paddr <= OFS_PARAM7 && apb_req_i.paddr[1:0] == 2'b00) begin
      nxt_prdata[7:0] = param_ff[apb_req_i.paddr[4:2]];
    end else if (apb_req_i.paddr == OFS_CMD) begin
      nxt_prdata[7:0] = cmd_ff;
    end else if (apb_req_i.paddr == OFS_RESULT) begin
      nxt_prdata[7:0] = result_ff;
    end else if (apb_req_i.paddr == OFS_INT_SRC) begin
      nxt_prdata[INT_DONE_BIT] = src_done_ff;
    end else if (apb_req_i.paddr == OFS_INT_MASK) begin
      nxt_prdata[INT_DONE_BIT] = mask_done_ff;
    end else begin
      nxt_pslverr = 1'b1;                                 // unmapped address
    end
  end

  // apb answer: ready in the cycle after setup, so no wait states
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      prdata_ff  <= RST_WORD;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (setup_ph) begin
      // read data is sampled at the setup edge; a result change in the
      // access cycle shows on the next read
      prdata_ff  <= apb_req_i.pwrite ? RST_WORD : nxt_prdata;
      pready_ff  <= 1'b1;
      pslverr_ff <= nxt_pslverr;
    end else begin
      prdata_ff  <= RST_WORD;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign prdata_o  = prdata_ff;
  assign pready_o  = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign busy_o    = busy_ff;
  assign irq_o     = irq_ff;

endmodule // atqe_engine

// ==== rtl/atqe_pkg.sv ====
// package of the address table query engine: register map, command codes,
// result codes, flag layout, entry and bus carrier types.
// assumes a 32-bit APB master and one 125 MHz clock in the surrounding system.
package atqe_pkg;

  // table size as built; the engine takes it as a parameter default
  localparam int unsigned TABLE_DEPTH  = 2048;  // entries held in the table
  localparam int unsigned PARAM_BYTES  = 8;     // parameter bytes zero to seven

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_PARAM0   = 8'h00;  // parameter byte 0, bytes step by 4
  localparam logic [7:0] OFS_PARAM7   = 8'h1C;  // parameter byte 7
  localparam logic [7:0] OFS_CMD      = 8'h20;  // command code register
  localparam logic [7:0] OFS_RESULT   = 8'h24;  // result code register
  localparam logic [7:0] OFS_INT_SRC  = 8'h28;  // interrupt source register
  localparam logic [7:0] OFS_INT_MASK = 8'h2C;  // interrupt mask register

  // command codes served by this engine
  localparam logic [7:0] CMD_NEXT_VALID = 8'h21;  // next valid entry
  localparam logic [7:0] CMD_FIRST_NEW  = 8'h30;  // first newly learned entry
  localparam logic [7:0] CMD_NEXT_NEW   = 8'h31;  // next newly learned entry
  localparam logic [7:0] CMD_FIRST_AGED = 8'h40;  // first aged-out entry
  localparam logic [7:0] CMD_NEXT_AGED  = 8'h41;  // next aged-out entry
  localparam logic [7:0] CMD_FIRST_LOCK = 8'h50;  // first locked entry
  localparam logic [7:0] CMD_NEXT_LOCK  = 8'h51;  // next locked entry
  localparam logic [7:0] CMD_FIRST_FILT = 8'h60;  // first filtered entry
  localparam logic [7:0] CMD_NEXT_FILT  = 8'h61;  // next filtered entry
  localparam logic [7:0] CMD_FIRST_PORT = 8'h80;  // first entry on a port
  localparam logic [7:0] CMD_NEXT_PORT  = 8'h81;  // next entry on a port
  localparam logic [7:0] CMD_SYS_RESET  = 8'hFF;  // clear logic and table

  // result codes: 01 busy, 10 done, 1 followed by a 4-bit error code
  localparam logic [7:0] RES_IDLE      = 8'h00;  // nothing run since reset
  localparam logic [7:0] RES_BUSY      = 8'h01;  // command executing
  localparam logic [7:0] RES_OK        = 8'h02;  // done without error
  localparam logic [7:0] RES_NOT_FOUND = 8'h11;  // error 0001, no matching entry
  localparam logic [7:0] RES_BAD_CMD   = 8'h12;  // error 0010, code not served

  // flag byte bit positions
  localparam int unsigned FLG_VALID  = 0;  // entry in use
  localparam int unsigned FLG_AGE    = 1;  // not visited this age cycle
  localparam int unsigned FLG_OLD    = 2;  // aged out
  localparam int unsigned FLG_NEW    = 3;  // newly learned
  localparam int unsigned FLG_LOCK   = 4;  // never changed or aged
  localparam int unsigned FLG_FILTER = 5;  // frames to it are dropped
  localparam logic [7:0]  FLG_MASK   = 8'h3F;  // bits 6 and 7 reserved

  // interrupt source bit for command done
  localparam int unsigned INT_DONE_BIT = 5;  // command done source

  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;         // byte registers
  localparam logic [31:0] RST_WORD = 32'h0000_0000; // read data

  // one table entry
  typedef struct packed {
    logic [47:0] mac;    // station address, msb first
    logic [7:0]  port;   // port identifier
    logic [7:0]  flags;  // flag byte
  } atqe_entry_t;

  // apb request side, driven by the master
  typedef struct packed {
    logic        psel;     // slave select
    logic        penable;  // access phase
    logic        pwrite;   // write when high
    logic [7:0]  paddr;    // byte address
    logic [31:0] pwdata;   // write data
  } atqe_apb_req_t;

  // which property a search looks for
  typedef enum logic [2:0] {
    SEL_VALID,
    SEL_NEW,
    SEL_AGED,
    SEL_LOCK,
    SEL_FILT,
    SEL_PORT
  } atqe_sel_t;

endpackage

// ==== bench/atqe_engine_sva.sv ====
// checker of the query engine: apb handshake, busy span and done interrupt.
// assumes it is bound into atqe_engine and sees only that module's ports.
`timescale 1ns/1ns
module atqe_engine_sva
  import atqe_pkg::*;
#(
  parameter int unsigned DEPTH = 16  // table entries
) (
  input wire logic                     core_clk_i,  // clock
  input wire logic                     rst_n_i,     // sync reset, low
  input wire atqe_pkg::atqe_apb_req_t  apb_req_i,   // apb request
  input wire logic [31:0]              prdata_o,    // read data
  input wire logic                     pready_o,    // ready
  input wire logic                     pslverr_o,   // slave error
  input wire logic                     ent_we_i,    // entry strobe
  input wire logic [$clog2(DEPTH)-1:0] ent_idx_i,   // entry index
  input wire atqe_pkg::atqe_entry_t    ent_i,       // entry data
  input wire logic                     busy_o,      // executing
  input wire logic                     irq_o        // masked done
);
  localparam int BUSY_MAX = DEPTH + 2;  // full scan plus margin
  logic acc_wr;   // write access phase
  logic cmd_wr;   // write access to the command register
  logic mask_ff;  // shadow of the done mask bit
  assign acc_wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
  assign cmd_wr = acc_wr && (apb_req_i.paddr == OFS_CMD);
  // shadow mask only moves on the edge where the write completes
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mask_ff <= 1'b0;
    end else if (acc_wr && pready_o && apb_req_i.paddr == OFS_INT_MASK) begin
      mask_ff <= apb_req_i.pwdata[INT_DONE_BIT];
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_READY_AFTER_SETUP: assert property (apb_req_i.psel && !apb_req_i.penable |=> pready_o)
    else $error("ready missing after setup");
  AST_READY_ONE_CYCLE: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
    else $error("slave error outside access");
  AST_RDATA_IDLE: assert property (!pready_o |-> prdata_o == RST_WORD)
    else $error("read data outside access");
  AST_BUSY_FROM_CMD: assert property ($rose(busy_o) |-> $past(cmd_wr, 2))
    else $error("busy without command write");
  AST_BUSY_ENDS: assert property ($rose(busy_o) |-> ##[1:BUSY_MAX] !busy_o)
    else $error("scan longer than table");
  AST_BUSY_READS_01: assert property (pready_o && !apb_req_i.pwrite
    && apb_req_i.paddr == OFS_RESULT && busy_o && $past(busy_o) |-> prdata_o[7:0] == RES_BUSY)
    else $error("result not busy while executing");
  AST_DONE_IRQ: assert property ($fell(busy_o) && mask_ff |-> ##[0:1] irq_o)
    else $error("done interrupt missing");
  AST_IRQ_MASKED: assert property (!$past(mask_ff) |-> !irq_o)
    else $error("interrupt while masked");
endmodule // atqe_engine_sva

bind atqe_engine atqe_engine_sva #(.DEPTH(DEPTH)) i_atqe_engine_sva (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .apb_req_i(apb_req_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .ent_we_i(ent_we_i), .ent_idx_i(ent_idx_i), .ent_i(ent_i),
  .busy_o(busy_o), .irq_o(irq_o));

// ==== bench/atqe_engine_tb.sv ====
// testbench of the query engine: apb master, table loader, reference search.
// assumes a 16-entry table and an engine that answers apb with no wait state.
`timescale 1ns/1ns
module atqe_engine_tb;
  import atqe_pkg::*;
  localparam int unsigned DP    = 16;     // short table keeps full misses brief
  localparam int          LIMIT = 60000;  // cycle ceiling of the whole run
  logic          core_clk_i = 1'b0;  // bench clock
  logic          rst_n_i    = 1'b0;  // reset, low
  atqe_apb_req_t req        = '0;    // apb request
  logic [31:0]   prdata_o;           // read data
  logic          pready_o;           // ready
  logic          pslverr_o;          // slave error
  logic          busy_o;             // executing
  logic          irq_o;              // interrupt
  logic          ent_we     = 1'b0;  // entry strobe
  logic [3:0]    ent_idx    = '0;    // entry index
  atqe_entry_t   ent        = '0;    // entry data
  atqe_entry_t   tbl [DP];           // reference table
  logic [7:0]    prm [8];            // reference parameter bytes
  int            ptr;                // reference read pointer
  logic          hit;                // last search matched
  logic [32:0]   exp_q [$];          // expected {slverr, data} of reads
  int            failures = 0;       // mismatches
  int            checked  = 0;       // comparisons
  int            cyc      = 0;       // cycle count
  int fb [5] = '{FLG_VALID, FLG_NEW, FLG_OLD, FLG_LOCK, FLG_FILTER};  // flag per kind
  logic [7:0] cf [6] = '{CMD_SYS_RESET, CMD_FIRST_NEW, CMD_FIRST_AGED,
                         CMD_FIRST_LOCK, CMD_FIRST_FILT, CMD_FIRST_PORT};  // slot 0 unused
  logic [7:0] cn [6] = '{CMD_NEXT_VALID, CMD_NEXT_NEW, CMD_NEXT_AGED,
                         CMD_NEXT_LOCK, CMD_NEXT_FILT, CMD_NEXT_PORT};
  always #4 core_clk_i = ~core_clk_i;
  atqe_engine #(.DEPTH(DP)) i_atqe_engine (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .apb_req_i(req),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .ent_we_i(ent_we), .ent_idx_i(ent_idx), .ent_i(ent),
    .busy_o(busy_o), .irq_o(irq_o));
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    checked++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watcher: every completed read is held against the oldest note
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      give_verdict();
    end
    if (pready_o === 1'b1 && req.psel && !req.pwrite) check({pslverr_o, prdata_o}, exp_q.pop_front());
  end
  // one apb transfer; the request stands until ready is seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge core_clk_i);
    req.penable <= 1'b1;
    @(posedge core_clk_i);
    while (pready_o !== 1'b1) @(posedge core_clk_i);
    req <= '0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic e, input logic [7:0] b);
    exp_q.push_back({e, 24'h00_0000, b});
    xfer(1'b0, a, 32'h0000_0000);
  endtask
  // busy lags the state by a cycle, so look one edge later
  task automatic wait_idle();
    @(posedge core_clk_i);
    for (int w = 0; w < 2 * DP && busy_o === 1'b1; w++) @(posedge core_clk_i);
  endtask
  function automatic int find(input int sel, input int from, input logic [7:0] p);
    for (int i = from; i < DP; i++) begin
      if (sel < 5 ? tbl[i].flags[fb[sel]] : (tbl[i].flags[FLG_VALID] && tbl[i].port == p))
        return i;
    end
    return -1;
  endfunction
  // one search: predict, issue, then read result and all eight bytes
  task automatic run(input int sel, input logic nxt, output logic h);
    int k;
    k = find(sel, nxt ? ptr + 1 : 0, prm[6]);
    xfer(1'b1, OFS_CMD, {24'h00_0000, nxt ? cn[sel] : cf[sel]});
    wait_idle();
    h = (k >= 0);
    if (h) begin
      ptr = k;
      for (int b = 0; b < 6; b++) prm[b] = tbl[k].mac[8*b +: 8];
      prm[6] = tbl[k].port;
      prm[7] = tbl[k].flags & FLG_MASK;
    end
    rd(OFS_RESULT, 1'b0, h ? RES_OK : RES_NOT_FOUND);
    for (int b = 0; b < 8; b++) rd(OFS_PARAM0 + 8'(4 * b), 1'b0, prm[b]);
  endtask
  initial begin
    void'($urandom(43));
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    foreach (prm[b]) prm[b] = 8'h00;
    ptr = 0;
    rd(OFS_RESULT, 1'b0, RES_IDLE);
    rd(8'h30, 1'b1, 8'h00);  // unmapped place answers with an error
    // random table, ports kept small so port searches find several
    for (int i = 0; i < DP; i++) begin
      tbl[i] = {$urandom(), $urandom()};
      tbl[i].port = 8'($urandom_range(3));
      ent_we <= 1'b1;
      ent_idx <= 4'(i);
      ent <= tbl[i];
      @(posedge core_clk_i);
    end
    ent_we <= 1'b0;
    @(posedge core_clk_i);
    // each kind: first (valid has no first code), then next until a miss, then a probe of the kept pointer
    for (int s = 0; s < 6; s++) begin
      if (s == 5) begin
        prm[6] = 8'($urandom_range(3));
        xfer(1'b1, OFS_PARAM0 + 8'h18, {24'h00_0000, prm[6]});
      end
      hit = 1'b1;
      if (s > 0) run(s, 1'b0, hit);
      for (int j = 0; j < DP && hit; j++) run(s, 1'b1, hit);
      run(0, 1'b1, hit);
    end
    xfer(1'b1, OFS_CMD, 32'h0000_0020);
    rd(OFS_RESULT, 1'b0, RES_BAD_CMD);
    rd(OFS_CMD, 1'b0, 8'h20);  // last accepted code reads back
    // done interrupt: earlier commands left the source set, so clear it first
    xfer(1'b1, OFS_INT_MASK, 32'h0000_0020);
    xfer(1'b1, OFS_INT_SRC, 32'h0000_0020);
    rd(OFS_INT_SRC, 1'b0, 8'h00);
    check({32'h0000_0000, irq_o}, {32'h0000_0000, 1'b0});
    run(1, 1'b0, hit);
    check({32'h0000_0000, irq_o}, {32'h0000_0000, 1'b1});
    rd(OFS_INT_SRC, 1'b0, 8'h20);
    // mask off: the source stays set, yet the line must drop
    xfer(1'b1, OFS_INT_MASK, 32'h0000_0000);
    rd(OFS_INT_MASK, 1'b0, 8'h00);
    check({32'h0000_0000, irq_o}, {32'h0000_0000, 1'b0});
    rd(OFS_INT_SRC, 1'b0, 8'h20);
    xfer(1'b1, OFS_INT_SRC, 32'h0000_0020);
    rd(OFS_INT_SRC, 1'b0, 8'h00);
    // system reset empties table, bytes and pointer
    xfer(1'b1, OFS_CMD, {24'h00_0000, CMD_SYS_RESET});
    wait_idle();
    foreach (tbl[i]) tbl[i] = '0;
    foreach (prm[b]) prm[b] = 8'h00;
    ptr = 0;
    rd(OFS_RESULT, 1'b0, RES_OK);
    run(1, 1'b0, hit);
    run(0, 1'b1, hit);
    // a miss scan of entries 1 to 15 is long enough to catch the busy code
    xfer(1'b1, OFS_CMD, {24'h00_0000, CMD_NEXT_VALID});
    rd(OFS_RESULT, 1'b0, RES_BUSY);
    wait_idle();
    rd(OFS_RESULT, 1'b0, RES_NOT_FOUND);
    give_verdict();
  end
endmodule // atqe_engine_tb
